// *** shared/rwpt_pkg.sv ***
// Constants, field layouts and carrier types of the real-time counter with periodic timer
//
// Operation
// - One selected kernel clock feeds both the counter and the periodic timer.
// - counter_enable_bit written 1 enables the counter, written 0 disables it.
// - tick_timer_on written 1 enables the periodic timer, written 0 disables it.
// - Periodic timer uses the shared prescaler; counter period comes from wrap_limit.
// - Prescaler is cleared and held at zero while both enables are 0, counts when either is 1.
// - First tick and first increment may come anywhere within one full period.
// - After the first interrupt the tick output toggles every half period.
// - Sixteen-cycle setting makes the tick output follow prescaler bit 3.
// - Wrap and compare events are pulses lasting one kernel clock period.
// - Events fire under exactly the conditions that set the matching flags.
// - Count reaching wrap_limit flags a wrap and returns the count to zero.
// - Count equal to compare_match flags a compare match.
// - Wrap and compare share one interrupt; the periodic timer has its own.
// - The tick interrupt condition occurs each time the selected period passes.
// - Any interrupt condition sets its flag whether or not it is enabled.
// - Request is active while enable and flag are set, until flag cleared.
// - Separate flag and enable registers for the counter and the periodic timer.
// - Counter runs in idle, in standby only with keep_running_asleep; timer always.
// - Prescaler field divides the kernel clock by two to its value.
package rwpt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_MAIN_CONTROL  = 5'h00;
  localparam logic [4:0] IDX_STATUS        = 5'h01;
  localparam logic [4:0] IDX_IRQ_ENABLE    = 5'h02;
  localparam logic [4:0] IDX_IRQ_FLAG      = 5'h03;
  localparam logic [4:0] IDX_SOURCE_CHOICE = 5'h07;
  localparam logic [4:0] IDX_COUNT         = 5'h08;
  localparam logic [4:0] IDX_WRAP_LIMIT    = 5'h0A;
  localparam logic [4:0] IDX_COMPARE       = 5'h0C;
  localparam logic [4:0] IDX_TICK_CONTROL  = 5'h10;
  localparam logic [4:0] IDX_TICK_STATUS   = 5'h11;
  localparam logic [4:0] IDX_TICK_IRQ_EN   = 5'h12;
  localparam logic [4:0] IDX_TICK_FLAG     = 5'h13;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MC_ENABLE_POS  = 0;
  localparam int MC_PRESC_POS   = 3;
  localparam int MC_ASLEEP_POS  = 7;
  localparam int FLAG_WRAP_POS  = 0;
  localparam int FLAG_CMP_POS   = 1;
  localparam int TC_ON_POS      = 0;
  localparam int TC_PERIOD_POS  = 3;
  localparam int TICK_FLAG_POS  = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_MAIN_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_TICK_CONTROL  = 8'h00;
  localparam logic [1:0]  RST_SOURCE_CHOICE = 2'h0;
  localparam logic [15:0] RST_WRAP_LIMIT    = 16'hFFFF;
  localparam logic [15:0] RST_COMPARE       = 16'h0000;
  localparam logic [15:0] RST_COUNT         = 16'h0000;
  localparam int          PRESC_W           = 15;
  localparam logic [3:0]  PERIOD_OFF        = 4'h0;
  localparam logic [3:0]  PERIOD_SIXTEEN    = 4'h3;
  localparam logic [3:0]  PERIOD_MAX        = 4'hE;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       keep_running_asleep;
    logic [3:0] prescaler;
    logic       counter_enable_bit;
  } rwpt_main_ctrl_t;

  typedef struct packed {
    logic [3:0] period;
    logic       tick_timer_on;
  } rwpt_tick_ctrl_t;

  typedef struct packed {
    logic compare_match;
    logic wrap_event;
  } rwpt_cnt_ev_t;

  typedef enum logic [0:0] {
    RWPT_W_COLLECT = 1'b0,
    RWPT_W_RESP    = 1'b1
  } rwpt_wstate_t;

  typedef enum logic [0:0] {
    RWPT_R_IDLE = 1'b0,
    RWPT_R_DATA = 1'b1
  } rwpt_rstate_t;

endpackage

// *** design/rwpt_flags.sv ***
// Sticky flag bank where a hardware set beats a software clear
`timescale 1ns/10ps
`default_nettype none
module rwpt_flags #(
  parameter int N = 3
) (
  input  wire logic         clk,     // System clock
  input  wire logic         arst_n,  // Asynchronous reset, active low
  input  wire logic         ce,      // Clock enable, freezes flags when low
  input  wire logic [N-1:0] set,     // Hardware event per flag
  input  wire logic [N-1:0] clr,     // Software clear per flag
  output logic      [N-1:0] flag_r   // Sticky flags
);

  logic [N-1:0] flag_nxt;

  // ----------------------------------------------------------------
  // Per-bit next value
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    // Set wins when it lands in the clearing cycle
    assign flag_nxt[i] = set[i] | (flag_r[i] & ~clr[i]);
  end

  // Register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= '0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end

endmodule
`default_nettype wire

// *** design/rwpt_top.sv ***
// Real-time counter with periodic timer behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module rwpt_top
  import rwpt_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int NSRC   = 4,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,            // System clock, 100 MHz
  input  wire logic              arst_n,         // Asynchronous reset, active low
  input  wire logic              ce,             // Clock enable, freezes all state
  input  wire logic [NSRC-1:0]   kernel_tick,    // One-cycle pulse per kernel clock, per source
  input  wire logic              sleep_standby,  // Device is in standby sleep
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
  input  wire logic [2:0]        s_axi_awprot,   // Write protection, unused
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire logic [31:0]       s_axi_wdata,    // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte strobes
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  output logic [1:0]             s_axi_bresp,    // Write response
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
  input  wire logic [2:0]        s_axi_arprot,   // Read protection, unused
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  output logic [31:0]            s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   s_axi_rvalid,   // Read data valid
  input  wire logic              s_axi_rready,   // Read data ready
  output logic                   irq_counter,    // Wrap and compare interrupt request
  output logic                   irq_tick,       // Periodic timer interrupt request
  output rwpt_cnt_ev_t           cnt_events,     // Wrap and compare event pulses
  output logic                   tick_wave       // Periodic timer square output
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 16) begin : g_chk_cnt
    $error("CNT_W must lie between 1 and 16");
  end
  if (NSRC < 1 || NSRC > 4) begin : g_chk_src
    $error("NSRC must lie between 1 and 4");
  end
  if (ADDR_W < 7) begin : g_chk_addr
    $error("ADDR_W must be at least 7");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rwpt_wstate_t      wst_r, wst_nxt;
  rwpt_rstate_t      rst_r, rst_nxt;
  logic              aw_have_r, aw_have_nxt;
  logic              w_have_r, w_have_nxt;
  logic [4:0]        waddr_r, waddr_nxt;
  logic              wbad_r, wbad_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic              do_wr;
  logic [4:0]        ridx;
  logic              rbad;

  rwpt_main_ctrl_t   mc_r, mc_nxt;
  rwpt_tick_ctrl_t   tc_r, tc_nxt;
  logic [1:0]        irq_en_r, irq_en_nxt;
  logic              tick_en_r, tick_en_nxt;
  logic [1:0]        src_r, src_nxt;
  logic [CNT_W-1:0]  per_r, per_nxt;
  logic [CNT_W-1:0]  cmp_r, cmp_nxt;

  logic [PRESC_W-1:0] presc_r, presc_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  rwpt_cnt_ev_t       ev_r, ev_nxt;
  logic               tick_prev_r, tick_prev_nxt;
  logic [3:0]         ktick_all;
  logic               ktick;
  logic               run_cnt;
  logic               presc_on;
  logic [PRESC_W-1:0] pmask;
  logic               cnt_tick;
  logic               wrap_hit;
  logic               cmp_hit;
  logic               tick_level;
  logic               tick_rise;
  logic [2:0]         flag_set;
  logic [2:0]         flag_clr;
  logic [2:0]         flags;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Address map check
  function automatic logic mapped(input logic [4:0] idx);
    case (idx)
      IDX_MAIN_CONTROL, IDX_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_FLAG,
      IDX_SOURCE_CHOICE, IDX_COUNT, IDX_WRAP_LIMIT, IDX_COMPARE,
      IDX_TICK_CONTROL, IDX_TICK_STATUS, IDX_TICK_IRQ_EN, IDX_TICK_FLAG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_r && (wst_r == RWPT_W_COLLECT);
  assign s_axi_wready  = !w_have_r && (wst_r == RWPT_W_COLLECT);
  assign s_axi_bvalid  = (wst_r == RWPT_W_RESP);
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = (rst_r == RWPT_R_IDLE);
  assign s_axi_rvalid  = (rst_r == RWPT_R_DATA);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign do_wr         = aw_have_r && w_have_r && (wst_r == RWPT_W_COLLECT) && !wbad_r;
  assign ridx          = s_axi_araddr[6:2];
  assign rbad          = (|s_axi_araddr[ADDR_W-1:7]) || !mapped(ridx);

  // Bus channel next state and read mux
  always_comb begin
    wst_nxt     = wst_r;
    rst_nxt     = rst_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    waddr_nxt   = waddr_r;
    wbad_nxt    = wbad_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bresp_nxt   = bresp_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr[6:2];
      wbad_nxt    = (|s_axi_awaddr[ADDR_W-1:7]) || !mapped(s_axi_awaddr[6:2]);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    case (wst_r)
      RWPT_W_COLLECT: begin
        if (aw_have_r && w_have_r) begin
          wst_nxt     = RWPT_W_RESP;
          bresp_nxt   = wbad_r ? RESP_SLVERR : RESP_OKAY;
          aw_have_nxt = 1'b0;
          w_have_nxt  = 1'b0;
        end
      end
      RWPT_W_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = RWPT_W_COLLECT;
        end
      end
      default: wst_nxt = RWPT_W_COLLECT;
    endcase
    case (rst_r)
      RWPT_R_IDLE: begin
        if (s_axi_arvalid) begin
          rst_nxt   = RWPT_R_DATA;
          rresp_nxt = rbad ? RESP_SLVERR : RESP_OKAY;
          rdata_nxt = 32'h0000_0000;
          if (!rbad) begin
            case (ridx)
              IDX_MAIN_CONTROL: begin
                rdata_nxt[MC_ASLEEP_POS]       = mc_r.keep_running_asleep;
                rdata_nxt[MC_PRESC_POS +: 4]   = mc_r.prescaler;
                rdata_nxt[MC_ENABLE_POS]       = mc_r.counter_enable_bit;
              end
              IDX_IRQ_ENABLE:    rdata_nxt[1:0] = irq_en_r;
              IDX_IRQ_FLAG:      rdata_nxt[1:0] = flags[1:0];
              IDX_SOURCE_CHOICE: rdata_nxt[1:0] = src_r;
              IDX_COUNT:         rdata_nxt[CNT_W-1:0] = cnt_r;
              IDX_WRAP_LIMIT:    rdata_nxt[CNT_W-1:0] = per_r;
              IDX_COMPARE:       rdata_nxt[CNT_W-1:0] = cmp_r;
              IDX_TICK_CONTROL: begin
                rdata_nxt[TC_PERIOD_POS +: 4] = tc_r.period;
                rdata_nxt[TC_ON_POS]          = tc_r.tick_timer_on;
              end
              IDX_TICK_IRQ_EN:   rdata_nxt[TICK_FLAG_POS] = tick_en_r;
              IDX_TICK_FLAG:     rdata_nxt[TICK_FLAG_POS] = flags[2];
              default:           rdata_nxt = 32'h0000_0000;
            endcase
          end
        end
      end
      RWPT_R_DATA: begin
        if (s_axi_rready) begin
          rst_nxt = RWPT_R_IDLE;
        end
      end
      default: rst_nxt = RWPT_R_IDLE;
    endcase
  end

  // Bus channel registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wst_r     <= RWPT_W_COLLECT;
      rst_r     <= RWPT_R_IDLE;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      waddr_r   <= 5'h00;
      wbad_r    <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      wst_r     <= wst_nxt;
      rst_r     <= rst_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      waddr_r   <= waddr_nxt;
      wbad_r    <= wbad_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bresp_r   <= bresp_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m           = 32'h0000_0000;
    mc_nxt      = mc_r;
    tc_nxt      = tc_r;
    irq_en_nxt  = irq_en_r;
    tick_en_nxt = tick_en_r;
    src_nxt     = src_r;
    per_nxt     = per_r;
    cmp_nxt     = cmp_r;
    if (do_wr) begin
      case (waddr_r)
        IDX_MAIN_CONTROL: begin
          if (wstrb_r[0]) begin
            mc_nxt.keep_running_asleep = wdata_r[MC_ASLEEP_POS];
            mc_nxt.prescaler           = wdata_r[MC_PRESC_POS +: 4];
            mc_nxt.counter_enable_bit  = wdata_r[MC_ENABLE_POS];
          end
        end
        IDX_IRQ_ENABLE: begin
          if (wstrb_r[0]) begin
            irq_en_nxt = wdata_r[1:0];
          end
        end
        IDX_SOURCE_CHOICE: begin
          if (wstrb_r[0]) begin
            src_nxt = wdata_r[1:0];
          end
        end
        IDX_WRAP_LIMIT: begin
          m       = wmerge(32'(per_r), wdata_r, wstrb_r);
          per_nxt = m[CNT_W-1:0];
        end
        IDX_COMPARE: begin
          m       = wmerge(32'(cmp_r), wdata_r, wstrb_r);
          cmp_nxt = m[CNT_W-1:0];
        end
        IDX_TICK_CONTROL: begin
          if (wstrb_r[0]) begin
            tc_nxt.period        = wdata_r[TC_PERIOD_POS +: 4];
            tc_nxt.tick_timer_on = wdata_r[TC_ON_POS];
          end
        end
        IDX_TICK_IRQ_EN: begin
          if (wstrb_r[0]) begin
            tick_en_nxt = wdata_r[TICK_FLAG_POS];
          end
        end
        default: m = 32'h0000_0000;
      endcase
    end
  end

  // Configuration register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mc_r      <= rwpt_main_ctrl_t'({RST_MAIN_CONTROL[MC_ASLEEP_POS],
                                      RST_MAIN_CONTROL[MC_PRESC_POS +: 4],
                                      RST_MAIN_CONTROL[MC_ENABLE_POS]});
      tc_r      <= rwpt_tick_ctrl_t'({RST_TICK_CONTROL[TC_PERIOD_POS +: 4],
                                      RST_TICK_CONTROL[TC_ON_POS]});
      irq_en_r  <= 2'h0;
      tick_en_r <= 1'b0;
      src_r     <= RST_SOURCE_CHOICE;
      per_r     <= RST_WRAP_LIMIT[CNT_W-1:0];
      cmp_r     <= RST_COMPARE[CNT_W-1:0];
    end else if (ce) begin
      mc_r      <= mc_nxt;
      tc_r      <= tc_nxt;
      irq_en_r  <= irq_en_nxt;
      tick_en_r <= tick_en_nxt;
      src_r     <= src_nxt;
      per_r     <= per_nxt;
      cmp_r     <= cmp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, counter, events and periodic timer
  // ----------------------------------------------------------------
  assign ktick_all  = 4'(kernel_tick);
  assign ktick      = ktick_all[src_r];
  assign run_cnt    = mc_r.counter_enable_bit && (!sleep_standby || mc_r.keep_running_asleep);
  assign presc_on   = mc_r.counter_enable_bit || tc_r.tick_timer_on;
  assign pmask      = ~({PRESC_W{1'b1}} << mc_r.prescaler);
  assign cnt_tick   = ktick && run_cnt && ((presc_r & pmask) == pmask);
  assign wrap_hit   = cnt_tick && (cnt_r == per_r);
  assign cmp_hit    = cnt_tick && (cnt_r == cmp_r);
  // Tick output follows prescaler bit PERIOD, giving a 2^(PERIOD+1) square wave
  assign tick_level = tc_r.tick_timer_on && (tc_r.period != PERIOD_OFF) &&
                      (tc_r.period <= PERIOD_MAX) && presc_r[tc_r.period];
  assign tick_rise  = tick_level && !tick_prev_r;

  // Timing next state
  always_comb begin
    logic [31:0] m;
    m             = 32'h0000_0000;
    presc_nxt     = presc_r;
    cnt_nxt       = cnt_r;
    ev_nxt        = ev_r;
    tick_prev_nxt = tick_level;
    if (!presc_on) begin
      presc_nxt = '0;
    end else if (ktick) begin
      presc_nxt = presc_r + PRESC_W'(1);
    end
    if (do_wr && waddr_r == IDX_COUNT) begin
      m       = wmerge(32'(cnt_r), wdata_r, wstrb_r);
      cnt_nxt = m[CNT_W-1:0];
    end else if (wrap_hit) begin
      cnt_nxt = '0;
    end else if (cnt_tick) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    // Events hold for exactly one kernel clock period
    if (ktick) begin
      ev_nxt.wrap_event    = wrap_hit;
      ev_nxt.compare_match = cmp_hit;
    end
  end

  // Timing register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_r     <= '0;
      cnt_r       <= RST_COUNT[CNT_W-1:0];
      ev_r        <= '0;
      tick_prev_r <= 1'b0;
    end else if (ce) begin
      presc_r     <= presc_nxt;
      cnt_r       <= cnt_nxt;
      ev_r        <= ev_nxt;
      tick_prev_r <= tick_prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------------------------------
  assign flag_set = {tick_rise, cmp_hit, wrap_hit};
  assign flag_clr[FLAG_WRAP_POS] = do_wr && waddr_r == IDX_IRQ_FLAG && wstrb_r[0] && wdata_r[FLAG_WRAP_POS];
  assign flag_clr[FLAG_CMP_POS]  = do_wr && waddr_r == IDX_IRQ_FLAG && wstrb_r[0] && wdata_r[FLAG_CMP_POS];
  assign flag_clr[2] = do_wr && waddr_r == IDX_TICK_FLAG && wstrb_r[0] && wdata_r[TICK_FLAG_POS];

  rwpt_flags #(
    .N (3)
  ) u_flags (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .set    (flag_set),
    .clr    (flag_clr),
    .flag_r (flags)
  );

  // Shared counter vector, separate tick vector
  assign irq_counter = |(flags[1:0] & irq_en_r);
  assign irq_tick    = flags[2] && tick_en_r;
  assign cnt_events  = ev_r;
  assign tick_wave   = tick_prev_r;

endmodule
`default_nettype wire

// *** verif/rwpt_checker.sv ***
// Port checks of the counter with periodic timer
`timescale 1ns/10ps
`default_nettype none
module rwpt_checker
  import rwpt_pkg::*;
#(
  parameter int NSRC = 4
) (
  input wire logic            clk,           // Clock
  input wire logic            arst_n,        // Reset
  input wire logic [NSRC-1:0] kernel_tick,   // Kernel ticks
  input wire logic            s_axi_awvalid, // AW valid
  input wire logic            s_axi_awready, // AW ready
  input wire logic            s_axi_wvalid,  // W valid
  input wire logic            s_axi_wready,  // W ready
  input wire logic            s_axi_bvalid,  // B valid
  input wire logic            s_axi_bready,  // B ready
  input wire logic            s_axi_arvalid, // AR valid
  input wire logic            s_axi_arready, // AR ready
  input wire logic            s_axi_rvalid,  // R valid
  input wire logic            s_axi_rready,  // R ready
  input wire logic [31:0]     s_axi_rdata,   // R data
  input wire logic            irq_counter,   // Counter request
  input wire logic            irq_tick,      // Tick request
  input wire rwpt_cnt_ev_t    cnt_events     // Event pulses
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  wr_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
    !s_axi_awready ##1 s_axi_bvalid) else $error("write not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  // ----------------------------------------------------------------
  // Events and requests
  // ----------------------------------------------------------------
  ev_tick_a: assert property (cnt_events != $past(cnt_events) |-> $past(|kernel_tick))
    else $error("event moved without kernel tick");
  irqc_clr_a: assert property ($fell(irq_counter) |-> s_axi_bvalid) else $error("counter request lost");
  irqt_clr_a: assert property ($fell(irq_tick) |-> s_axi_bvalid) else $error("tick request lost");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench of the counter with periodic timer
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import rwpt_pkg::*;
;
  logic         clk, awr, wr, bv, arr, rv, irqc, irqt, wave;
  logic         arst_n = 1'b0, slp = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [3:0]   kt = 4'h0;
  logic [2:0]   kd = 3'h0;
  logic [7:0]   awa = 8'h00, ara = 8'h00;
  logic [31:0]  wd = 32'h0, rd, v;
  logic [1:0]   br, rr, rs;
  rwpt_cnt_ev_t ev;
  int           fails = 0, comparisons = 0, n, evn = 0;
  rwpt_top i_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .kernel_tick(kt), .sleep_standby(slp),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .irq_counter(irqc),
    .irq_tick(irqt), .cnt_events(ev), .tick_wave(wave));
  // Clock and kernel ticks: source 0 every 4 cycles, source 1 every 8
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    kd <= kd + 3'h1;
    kt <= {2'h0, kd == 3'h7, kd[1:0] == 2'h3};
    evn <= evn + ev.wrap_event;
  end
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wreg(input logic [4:0] i, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awa <= {1'b0, i, 2'h0};
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do @(negedge clk); while (!(awr && wr));
    @(posedge clk);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(negedge clk); while (!bv);
    chk("bresp", {30'h0, br}, {30'h0, e});
    @(posedge clk);
    bry <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] i);
    @(posedge clk);
    ara <= {1'b0, i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    v  = rd;
    rs = rr;
    @(posedge clk);
    rry <= 1'b0;
  endtask
  task automatic end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rreg(IDX_STATUS);
    chk("busy", v, 32'h0);
    rreg(IDX_TICK_STATUS);
    chk("tbusy", v, 32'h0);
    rreg(IDX_WRAP_LIMIT);
    chk("wrap_limit reset", v, 32'h0000FFFF);
    rreg(5'h06);
    chk("unmapped read", {rs, v[29:0]}, {RESP_SLVERR, 30'h0});
    wreg(5'h06, 32'h1, RESP_SLVERR);
    // Count rate for two prescaler settings, 40 counts each
    for (int p = 0; p < 4; p += 2) begin
      wreg(IDX_COUNT, 32'h0, RESP_OKAY);
      wreg(IDX_MAIN_CONTROL, 32'h1 | (p << 3), RESP_OKAY);
      repeat (160 << p) @(posedge clk);
      wreg(IDX_MAIN_CONTROL, 32'h0, RESP_OKAY);
      rreg(IDX_COUNT);
      chk("count rate", v >= 39 && v <= 42, 32'h1);
    end
    // Wrap at 3, compare at 2, only wrap enabled
    wreg(IDX_WRAP_LIMIT, 32'h3, RESP_OKAY);
    wreg(IDX_COMPARE, 32'h2, RESP_OKAY);
    wreg(IDX_IRQ_ENABLE, 32'h1, RESP_OKAY);
    wreg(IDX_COUNT, 32'h0, RESP_OKAY);
    wreg(IDX_MAIN_CONTROL, 32'h1, RESP_OKAY);
    repeat (40) @(posedge clk);
    wreg(IDX_MAIN_CONTROL, 32'h0, RESP_OKAY);
    rreg(IDX_COUNT);
    chk("wrapped count", v <= 3, 32'h1);
    rreg(IDX_IRQ_FLAG);
    chk("flags and request", {irqc, v[1:0]}, 32'h7);
    chk("wrap ev", evn % 4 == 0 && evn > 0, 32'h1);
    wreg(IDX_IRQ_FLAG, 32'h1, RESP_OKAY);
    rreg(IDX_IRQ_FLAG);
    chk("after wrap clear", {irqc, v[1:0]}, 32'h2);
    // Standby halts the counter unless asked to keep running
    slp <= 1'b1;
    wreg(IDX_WRAP_LIMIT, 32'hFFFF, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      wreg(IDX_COUNT, 32'h0, RESP_OKAY);
      wreg(IDX_MAIN_CONTROL, 32'h1 | (k << 7), RESP_OKAY);
      repeat (40) @(posedge clk);
      wreg(IDX_MAIN_CONTROL, 32'h0, RESP_OKAY);
      rreg(IDX_COUNT);
      chk("standby count", v != 0, k);
    end
    // Tick timer on source 1 in standby: 16 kernel cycles of 8 clocks
    wreg(IDX_SOURCE_CHOICE, 32'h1, RESP_OKAY);
    wreg(IDX_TICK_IRQ_EN, 32'h1, RESP_OKAY);
    wreg(IDX_TICK_CONTROL, 32'h19, RESP_OKAY);
    while (!wave) @(negedge clk);
    n = 0;
    while (wave) begin
      n++;
      @(negedge clk);
    end
    chk("half period", n, 32'd64);
    while (!wave) begin
      n++;
      @(negedge clk);
    end
    chk("full period", n, 32'd128);
    wreg(IDX_TICK_CONTROL, 32'h0, RESP_OKAY);
    rreg(IDX_TICK_FLAG);
    chk("tick flag and request", {irqt, v[0]}, 32'h3);
    wreg(IDX_TICK_FLAG, 32'h1, RESP_OKAY);
    chk("tick request cleared", irqt, 32'h0);
    end_sim();
  end
endmodule
bind rwpt_top rwpt_checker #(.NSRC(NSRC)) i_chk (.clk, .arst_n, .kernel_tick, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .irq_counter, .irq_tick, .cnt_events);
`default_nettype wire
